// *** hdl/msc_mode_select.sv ***
// Mode select register with bidirectional stream steering and block fill engine
// Functional notes
// [RQ1] Upper bidir bit 7: streams 16-31 inputs forced low, outputs bidirectional.
// [RQ2] Lower bidir bit 6: streams 0-15 inputs forced low, outputs bidirectional.
// [RQ3] Receiver global enable bit 5 low keeps every BER receiver off.
// [RQ4] Transmitter global enable bit 4 low keeps every BER transmitter off.
// [RQ5] With arm and go high, fill value bits 3-1 goes into every low memory word.
// [RQ6] Writing one to go while go is zero and arm is high starts block programming across the memory.
// [RQ7] Clearing go or arm during programming aborts; software keeps other bits steady.
`timescale 1ns/10ps
`default_nettype none

module msc_mode_select
	import msc_pkg::*;
#(
	parameter int CM_DEPTH = msc_pkg::MSC_CM_DEPTH
)(
	// Clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      reset_n,
	// Register port
	input  wire logic [3:0]                reg_addr,
	input  wire logic [15:0]               reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [15:0]               reg_rdata,
	// Arm bit held in the control register
	input  wire logic                      block_fill_arm,
	// Stream pins
	input  wire logic [MSC_STREAMS-1:0]    serial_input_streams,
	input  wire logic [MSC_STREAMS-1:0]    serial_output_streams_in,
	output logic      [MSC_STREAMS-1:0]    stream_in_core,
	output logic      [MSC_STREAMS-1:0]    stream_bidir_en,
	// BER global enables
	output logic                           ber_rx_allow,
	output logic                           ber_tx_allow,
	// Low connection memory write port
	output msc_pkg::msc_cm_wr_t            cm_low_wr,
	output logic                           fill_busy
);

	import msc_pkg::*;

	localparam int AW = $clog2(CM_DEPTH);

	initial
	begin
		if (CM_DEPTH < 2 || CM_DEPTH > 2048 || (CM_DEPTH & (CM_DEPTH - 1)) != 0)
			$error("CM_DEPTH must be a power of two from 2 to 2048");
	end

	// ==========================================================
	// Helpers
	// True while the engine walks the memory
	function automatic logic is_filling(input msc_state_t s);
		is_filling = (s == MSC_FILL);
	endfunction

	// ==========================================================
	// Pin synchronisers
	logic [MSC_STREAMS-1:0] sin_s1_q;
	logic [MSC_STREAMS-1:0] sin_s2_q;
	logic [MSC_STREAMS-1:0] sio_s1_q;
	logic [MSC_STREAMS-1:0] sio_s2_q;
	logic                   arm_s1_q;
	logic                   arm_s2_q;

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sin_s1_q <= '0;
			sin_s2_q <= '0;
			sio_s1_q <= '0;
			sio_s2_q <= '0;
			arm_s1_q <= 1'b0;
			arm_s2_q <= 1'b0;
		end
		else
		begin
			sin_s1_q <= serial_input_streams;
			sin_s2_q <= sin_s1_q;
			sio_s1_q <= serial_output_streams_in;
			sio_s2_q <= sio_s1_q;
			arm_s1_q <= block_fill_arm;
			arm_s2_q <= arm_s1_q;
		end
	end

	// ==========================================================
	// Register decode
	logic [15:0]  mode_q;
	logic [15:0]  mode_d;
	msc_state_t   state_q;
	msc_state_t   state_d;
	logic [AW-1:0] addr_q;
	logic [AW-1:0] addr_d;
	logic [15:0]  rdata_d;

	wire          sel_mode   = (reg_addr == MSC_ADDR_MODE);
	wire          sel_status = (reg_addr == MSC_ADDR_STATUS);
	wire          wr_mode   = reg_wr && sel_mode;
	wire          go_now    = mode_q[MSC_BIT_GO];
	wire          go_rise   = wr_mode && reg_wdata[MSC_BIT_GO] && !go_now;
	wire          last_word = (addr_q == AW'(CM_DEPTH - 1));
	wire          filling   = is_filling(state_q);
	// Abort as soon as either go or arm drops while filling
	wire          abort     = filling && (!go_now || !arm_s2_q); // RQ7
	wire          done      = filling && !abort && last_word;
	wire [MSC_VAL_W-1:0] fill_val = mode_q[MSC_BIT_VAL_HI:MSC_BIT_VAL_LO];

	// Go self-clears when the fill completes; a software write in the same cycle wins
	always_comb
	begin
		mode_d = mode_q;
		if (done)
			mode_d[MSC_BIT_GO] = 1'b0;
		if (wr_mode)
			mode_d = reg_wdata & MSC_MODE_WMASK;
	end

	// ==========================================================
	// Fill engine
	always_comb
	begin
		state_d = state_q;
		addr_d  = addr_q;
		unique case (state_q)
			MSC_IDLE:
			begin
				if (go_rise && arm_s2_q) // RQ6
				begin
					state_d = MSC_FILL;
					addr_d  = '0;
				end
			end
			MSC_FILL:
			begin
				if (abort || done) // RQ7
					state_d = MSC_IDLE;
				else
					addr_d = addr_q + AW'(1);
			end
		endcase
	end

	// Idle cycles and unmapped addresses read zero so the read bus can be ORed
	assign rdata_d = !reg_rd ? 16'h0000 :
		sel_mode   ? mode_q :
		sel_status ? {15'h0000, filling} :
		16'h0000;

	// ==========================================================
	// Stream steering
	wire [MSC_STREAMS-1:0] bidir_mask = {{MSC_HALF{mode_q[MSC_BIT_UP_BIDIR]}}, // RQ1
	                                     {MSC_HALF{mode_q[MSC_BIT_LO_BIDIR]}}}; // RQ2
	// In bidirectional mode data enters through the output pins, inputs read low
	wire [MSC_STREAMS-1:0] core_in_d  = (sin_s2_q & ~bidir_mask) | (sio_s2_q & bidir_mask);

	// One word per cycle; an abort drops the strobe in the cycle it is seen
	msc_cm_wr_t cm_d;
	assign cm_d = '{
		we:   filling && !abort, // RQ5
		addr: 11'(addr_q),
		data: fill_val // RQ5
	};

	// ==========================================================
	// Control state
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mode_q  <= MSC_MODE_RESET;
			state_q <= MSC_IDLE;
			addr_q  <= '0;
		end
		else
		begin
			mode_q  <= mode_d;
			state_q <= state_d;
			addr_q  <= addr_d;
		end
	end

	// ==========================================================
	// Read port
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			reg_rdata <= 16'h0000;
		else
			reg_rdata <= rdata_d;
	end

	// ==========================================================
	// Registered outputs
	// BER gates take mode_d so they move on the same edge as the register
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			stream_in_core  <= '0;
			stream_bidir_en <= '0;
			ber_rx_allow    <= 1'b0;
			ber_tx_allow    <= 1'b0;
			cm_low_wr       <= '0;
			fill_busy       <= 1'b0;
		end
		else
		begin
			stream_in_core  <= core_in_d;
			stream_bidir_en <= bidir_mask;
			ber_rx_allow    <= mode_d[MSC_BIT_RX_ON]; // RQ3
			ber_tx_allow    <= mode_d[MSC_BIT_TX_ON]; // RQ4
			cm_low_wr       <= cm_d;
			fill_busy       <= is_filling(state_d);
		end
	end

endmodule

`default_nettype wire

// *** hdl/msc_pkg.sv ***
// Package for the mode select control register block
package msc_pkg;

	// ==========================================================
	// Register map
	localparam logic [3:0]  MSC_ADDR_MODE     = 4'h1;
	localparam logic [3:0]  MSC_ADDR_STATUS   = 4'h2;
	localparam logic [15:0] MSC_MODE_RESET    = 16'h0000;
	localparam logic [15:0] MSC_MODE_WMASK    = 16'h01FF;

	// ==========================================================
	// Field positions of internal_mode_select
	localparam int MSC_BIT_GO       = 0;
	localparam int MSC_BIT_VAL_LO   = 1;
	localparam int MSC_BIT_VAL_HI   = 3;
	localparam int MSC_BIT_TX_ON    = 4;
	localparam int MSC_BIT_RX_ON    = 5;
	localparam int MSC_BIT_LO_BIDIR = 6;
	localparam int MSC_BIT_UP_BIDIR = 7;

	// ==========================================================
	// Sizes
	localparam int MSC_STREAMS      = 32;
	localparam int MSC_HALF         = 16;
	localparam int MSC_CM_DEPTH     = 2048;
	localparam int MSC_VAL_W        = 3;

	// ==========================================================
	// Connection memory write port
	typedef struct packed {
		logic        we;
		logic [10:0] addr;
		logic [2:0]  data;
	} msc_cm_wr_t;

	typedef enum logic [0:0] {
		MSC_IDLE,
		MSC_FILL
	} msc_state_t;

endpackage

// *** verification/msc_mode_monitor.sv ***
// Checker for the mode select register block
`timescale 1ns/10ps
`default_nettype none
module msc_mode_monitor
	import msc_pkg::*;
(
	// Clock and reset
	input wire logic                   sys_clk,
	input wire logic                   reset_n,
	// Register port
	input wire logic [3:0]             reg_addr,
	input wire logic [15:0]            reg_wdata,
	input wire logic                   reg_wr,
	// Outputs
	input wire logic [MSC_STREAMS-1:0] stream_bidir_en,
	input wire logic                   ber_rx_allow,
	input wire logic                   ber_tx_allow,
	input wire msc_pkg::msc_cm_wr_t    cm_low_wr,
	input wire logic                   fill_busy
);
	// ==========
	// Helpers
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	wire w_mode = reg_wr && reg_addr == MSC_ADDR_MODE;
	logic [2:0] val_q;
	always_ff @(posedge sys_clk or negedge reset_n)
		if (!reset_n)
			val_q <= 3'h0;
		else if (w_mode)
			val_q <= reg_wdata[3:1];
	// ==========
	// Assertions
	a_up_bidir: assert property (w_mode |-> ##2 stream_bidir_en[31:16] == {16{$past(reg_wdata[7], 2)}})
		else $error("upper bidir wrong");
	a_lo_bidir: assert property (w_mode |-> ##2 stream_bidir_en[15:0] == {16{$past(reg_wdata[6], 2)}})
		else $error("lower bidir wrong");
	a_rx_gate: assert property (w_mode |=> ber_rx_allow == $past(reg_wdata[5]))
		else $error("rx enable wrong");
	a_tx_gate: assert property (w_mode |=> ber_tx_allow == $past(reg_wdata[4]))
		else $error("tx enable wrong");
	a_fill_data: assert property (cm_low_wr.we |-> cm_low_wr.data == val_q)
		else $error("fill data wrong");
	a_addr_step: assert property (cm_low_wr.we && $past(cm_low_wr.we) |-> cm_low_wr.addr == $past(cm_low_wr.addr) + 11'h001)
		else $error("fill address skip");
	a_fill_start: assert property ($rose(fill_busy) |-> $past(w_mode) && $past(reg_wdata[0]))
		else $error("fill without go");
	a_go_abort: assert property (fill_busy && w_mode && !reg_wdata[0] |-> ##2 !cm_low_wr.we)
		else $error("abort ignored");
	cover property ($rose(fill_busy));
	cover property ($fell(fill_busy));
	cover property (w_mode && reg_wdata[7]);
endmodule
`default_nettype wire

// *** verification/msc_mode_select_bench.sv ***
// Bench for the mode select register block
`timescale 1ns/10ps
`default_nettype none
module msc_mode_select_bench;
	import msc_pkg::*;
	logic clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, arm = 0, rx, tx, busy;
	logic [3:0] addr = 4'h0;
	logic [15:0] wd = 16'h0000, rdat;
	logic [31:0] sin = 32'hA5A5_3C3C, sout = 32'h0F0F_F0F0, core, bden;
	logic [2:0] fval = 3'h0;
	msc_cm_wr_t cm;
	int err_total = 0, num_checks = 0, n_we = 0, cyc = 0;
	msc_mode_select #(.CM_DEPTH(16)) u_dut (.sys_clk(clk), .reset_n(rst_n), .reg_addr(addr), .reg_wdata(wd),
		.reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdat), .block_fill_arm(arm), .serial_input_streams(sin),
		.serial_output_streams_in(sout), .stream_in_core(core), .stream_bidir_en(bden), .ber_rx_allow(rx),
		.ber_tx_allow(tx), .cm_low_wr(cm), .fill_busy(busy));
	initial forever #2 clk = ~clk;
	task automatic chk(input string n, input logic [31:0] e, g);
		num_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ==========
	// Bus tasks; each starts at a fresh edge so strobes never collide
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 chk("rdata", {16'h0, e}, {16'h0, rdat});
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	always @(negedge clk)
		if (cm.we === 1'b1)
		begin
			chk("addr", n_we, {21'h0, cm.addr});
			chk("data", {29'h0, fval}, {29'h0, cm.data});
			n_we++;
		end
	always @(posedge clk)
		if (++cyc == 3000)
		begin
			err_total++;
			report_and_stop();
		end
	// ==========
	// Tests
	initial
	begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(MSC_ADDR_MODE, 16'h0000);
		wr(MSC_ADDR_MODE, 16'h0080);
		idle(5);
		chk("bidir", 32'hFFFF_0000, bden);
		chk("core", 32'h0F0F_3C3C, core);
		chk("rxtx", 0, {rx, tx});
		wr(MSC_ADDR_MODE, 16'h0070);
		idle(5);
		chk("bidir", 32'h0000_FFFF, bden);
		chk("core", 32'hA5A5_F0F0, core);
		chk("rxtx", 3, {rx, tx});
		wr(MSC_ADDR_MODE, 16'hFFFE);
		wr(4'hF, 16'hFFFF);
		rd(4'hF, 16'h0000);
		rd(MSC_ADDR_MODE, 16'h01FE);
		wr(MSC_ADDR_MODE, 16'h0001);
		idle(20);
		chk("unarmed", 0, n_we);
		wr(MSC_ADDR_MODE, 16'h0000);
		@(posedge clk) arm <= 1'b1;
		idle(3);
		fval = 3'h5;
		wr(MSC_ADDR_MODE, 16'h000B);
		idle(30);
		chk("count", 16, n_we);
		rd(MSC_ADDR_MODE, 16'h000A);
		n_we = 0;
		fval = 3'h3;
		wr(MSC_ADDR_MODE, 16'h0007);
		idle(3);
		rd(MSC_ADDR_STATUS, 16'h0001);
		wr(MSC_ADDR_MODE, 16'h0006);
		idle(5);
		chk("abort", 1, {busy, n_we < 16});
		n_we = 0;
		wr(MSC_ADDR_MODE, 16'h0007);
		idle(3);
		@(posedge clk) arm <= 1'b0;
		idle(8);
		chk("abort", 1, {busy, n_we < 16});
		report_and_stop();
	end
endmodule
bind msc_mode_select msc_mode_monitor u_mon (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .stream_bidir_en(stream_bidir_en), .ber_rx_allow(ber_rx_allow),
	.ber_tx_allow(ber_tx_allow), .cm_low_wr(cm_low_wr), .fill_busy(fill_busy));
`default_nettype wire
